/* File: src/gpio_ab_pkg.sv */
// constants for the port a / port b data register block
package gpio_ab_pkg;
	localparam int port_a_width = 15;
	localparam int port_b_width = 9;
	localparam int reg_width = 16;
	localparam logic [3:0] port_a_data_addr = 4'h0;
	localparam logic [3:0] port_b_data_addr = 4'h4;
	localparam logic [15:0] port_a_reset = 16'h0000;
	localparam logic [15:0] port_b_reset = 16'h0000;
	localparam logic [31:0] unmapped_read = 32'h00000000;
	localparam logic [1:0] func_port_in = 2'h0;
	localparam logic [1:0] func_port_out = 2'h1;
	localparam logic [1:0] func_reserved = 2'h2;
	localparam logic [1:0] func_other = 2'h3;
endpackage

/* File: src/gpio_port_a_b_data.sv */
// port a and port b data registers with avalon-mm slave and pin muxing
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// Function
// - port a bits 14..0 map to pins
// - port a bit 15 reads zero
// - port b bits 8..0 map to pins, 15..9 read zero
// - power-on reset clears port a data
// - power-on reset clears port b data
// - other resets and low power keep data
// - output mode reads stored bit
// - input mode reads sampled pin level
// - output mode write drives the pin
// - input mode write stores, pin undriven
// - other function reads pin, write stores only
// - select codes 00 in, 01 out, 11 other
module gpio_port_a_b_data
	import gpio_ab_pkg::*;
(
	// clock and power-on reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// function selects from pin function controller, two bits per pin
	input wire logic [2*gpio_ab_pkg::port_a_width-1:0] port_a_function_control,
	input wire logic [2*gpio_ab_pkg::port_b_width-1:0] port_b_function_control,
	// port a pins
	input wire logic [gpio_ab_pkg::port_a_width-1:0] port_a_pin_in,
	output logic [gpio_ab_pkg::port_a_width-1:0] port_a_pin_out,
	output logic [gpio_ab_pkg::port_a_width-1:0] port_a_pin_oe_n,
	// port b pins
	input wire logic [gpio_ab_pkg::port_b_width-1:0] port_b_pin_in,
	output logic [gpio_ab_pkg::port_b_width-1:0] port_b_pin_out,
	output logic [gpio_ab_pkg::port_b_width-1:0] port_b_pin_oe_n
);
	import gpio_ab_pkg::*;

	typedef struct packed {
		logic [port_a_width-1:0] port_a_pin_data;
		logic [port_b_width-1:0] port_b_pin_data;
		logic [port_a_width-1:0] a_sync1;
		logic [port_a_width-1:0] a_sync2;
		logic [port_b_width-1:0] b_sync1;
		logic [port_b_width-1:0] b_sync2;
		logic [31:0] rdata;
		logic ack;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic [port_a_width-1:0] a_is_out;
	logic [port_b_width-1:0] b_is_out;
	logic [port_a_width-1:0] a_view;
	logic [port_b_width-1:0] b_view;
	logic req;

	// only 01 drives; 00, 11 and reserved 10 leave the pin to others
	function automatic logic sel_is_out(input logic [1:0] sel);
		return sel == func_port_out;
	endfunction

	// per-pin read mux and drive enables for both ports
	genvar gi;
	generate
		for (gi = 0; gi < port_a_width; gi++)
		begin : g_pa
			assign a_is_out[gi] = sel_is_out(port_a_function_control[2*gi+:2]);
			// stored bit in output mode, sampled pin otherwise
			assign a_view[gi] = a_is_out[gi] ? st_r.port_a_pin_data[gi] : st_r.a_sync2[gi];
		end
		for (gi = 0; gi < port_b_width; gi++)
		begin : g_pb
			assign b_is_out[gi] = sel_is_out(port_b_function_control[2*gi+:2]);
			assign b_view[gi] = b_is_out[gi] ? st_r.port_b_pin_data[gi] : st_r.b_sync2[gi];
		end
	endgenerate

	// drive only pins in output mode; oe_n low means driving
	assign port_a_pin_out = st_r.port_a_pin_data;
	assign port_a_pin_oe_n = ~a_is_out;
	assign port_b_pin_out = st_r.port_b_pin_data;
	assign port_b_pin_oe_n = ~b_is_out;

	// answer one cycle after the request; waitrequest low on the ack cycle
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~st_r.ack;
	assign avs_readdata = st_r.rdata;

	// next state: sync pins, handle bus access
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.a_sync1 = port_a_pin_in;
		st_nxt.a_sync2 = st_r.a_sync1;
		st_nxt.b_sync1 = port_b_pin_in;
		st_nxt.b_sync2 = st_r.b_sync1;
		st_nxt.ack = req & ~st_r.ack;
		if (req & ~st_r.ack)
		begin
			// read data captured at acceptance, held until the next request
			if (avs_address == port_a_data_addr)
			begin
				st_nxt.rdata = {17'h0, a_view};
				// reserved bits are dropped whatever software sends
				if (avs_write & avs_byteenable[0])
					st_nxt.port_a_pin_data[7:0] = avs_writedata[7:0];
				if (avs_write & avs_byteenable[1])
					st_nxt.port_a_pin_data[14:8] = avs_writedata[14:8];
			end
			else if (avs_address == port_b_data_addr)
			begin
				st_nxt.rdata = {23'h0, b_view};
				if (avs_write & avs_byteenable[0])
					st_nxt.port_b_pin_data[7:0] = avs_writedata[7:0];
				if (avs_write & avs_byteenable[1])
					st_nxt.port_b_pin_data[8] = avs_writedata[8];
			end
			else
			begin
				st_nxt.rdata = unmapped_read;
			end
		end
	end

	// rst_n is the power-on reset; no other reset or low-power state touches data
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.port_a_pin_data <= port_a_reset[port_a_width-1:0];
			st_r.port_b_pin_data <= port_b_reset[port_b_width-1:0];
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// bus timing: exactly one wait cycle, never stalled while idle
	bus_answer_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus not answered in two cycles");

	idle_no_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!req |-> !avs_waitrequest)
		else $error("waitrequest high while idle");

	one_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(req && avs_waitrequest)
		|=> (!avs_waitrequest || !req))
		else $error("more than one wait cycle");

	rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(req && avs_waitrequest)
		|=> $stable(avs_readdata))
		else $error("read data moved without an access");

	unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address != port_a_data_addr
		&& avs_address != port_b_data_addr) |=> avs_readdata == unmapped_read)
		else $error("unmapped read not zero");

	// reserved bits never reach the read data
	a_reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		avs_readdata[31:15] == 17'h0)
		else $error("port a reserved read bits nonzero");

	b_reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && !avs_waitrequest && $past(avs_address) == port_b_data_addr)
		|-> avs_readdata[31:9] == 23'h0)
		else $error("port b reserved read bits nonzero");

	b_upper_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_b_data_addr)
		|=> avs_readdata[31:9] == 23'h0)
		else $error("port b upper read bits nonzero");

	// read mux per mode, in and out checked on the lowest and highest pin of each port, 10 and 11 on pin 0 only
	a_out_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_a_data_addr
		&& a_is_out[0]) |=> avs_readdata[0] == $past(st_r.port_a_pin_data[0]))
		else $error("output mode read not stored bit");

	a_in_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_a_data_addr
		&& !a_is_out[0]) |=> avs_readdata[0] == $past(st_r.a_sync2[0]))
		else $error("input mode read not pin level");

	a_top_out_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_a_data_addr
		&& a_is_out[14]) |=> avs_readdata[14] == $past(st_r.port_a_pin_data[14]))
		else $error("port a top bit read not stored bit");

	a_top_in_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_a_data_addr
		&& !a_is_out[14]) |=> avs_readdata[14] == $past(st_r.a_sync2[14]))
		else $error("port a top bit read not pin level");

	b_out_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_b_data_addr
		&& b_is_out[0]) |=> avs_readdata[0] == $past(st_r.port_b_pin_data[0]))
		else $error("port b output read not stored bit");

	b_in_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_b_data_addr
		&& !b_is_out[0]) |=> avs_readdata[0] == $past(st_r.b_sync2[0]))
		else $error("port b input read not pin level");

	b_top_out_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_b_data_addr
		&& b_is_out[8]) |=> avs_readdata[8] == $past(st_r.port_b_pin_data[8]))
		else $error("port b top bit read not stored bit");

	b_top_in_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_b_data_addr
		&& !b_is_out[8]) |=> avs_readdata[8] == $past(st_r.b_sync2[8]))
		else $error("port b top bit read not pin level");

	a_other_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_a_data_addr
		&& port_a_function_control[1:0] == func_other)
		|=> avs_readdata[0] == $past(st_r.a_sync2[0]))
		else $error("port a other function read not pin level");

	b_other_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_b_data_addr
		&& port_b_function_control[1:0] == func_other)
		|=> avs_readdata[0] == $past(st_r.b_sync2[0]))
		else $error("port b other function read not pin level");

	a_rsvd_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_a_data_addr
		&& port_a_function_control[1:0] == func_reserved)
		|=> avs_readdata[0] == $past(st_r.a_sync2[0]))
		else $error("port a reserved code read not pin level");

	b_rsvd_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && avs_waitrequest && avs_address == port_b_data_addr
		&& port_b_function_control[1:0] == func_reserved)
		|=> avs_readdata[0] == $past(st_r.b_sync2[0]))
		else $error("port b reserved code read not pin level");

	// stores: every accepted write lands, nothing else moves the data
	a_write_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_write && !avs_waitrequest && avs_address == port_a_data_addr
		&& avs_byteenable == 4'hF)
		|=> st_r.port_a_pin_data == $past(avs_writedata[14:0]))
		else $error("port a write not stored");

	b_write_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_write && !avs_waitrequest && avs_address == port_b_data_addr
		&& avs_byteenable == 4'hF)
		|=> st_r.port_b_pin_data == $past(avs_writedata[8:0]))
		else $error("port b write not stored");

	a_top_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_write && avs_waitrequest && avs_address == port_a_data_addr
		&& avs_byteenable[1]) |=> st_r.port_a_pin_data[14] == $past(avs_writedata[14]))
		else $error("port a top bit not written");

	b_top_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_write && avs_waitrequest && avs_address == port_b_data_addr
		&& avs_byteenable[1]) |=> st_r.port_b_pin_data[8] == $past(avs_writedata[8]))
		else $error("port b top bit not written");

	a_in_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_write && avs_waitrequest && avs_address == port_a_data_addr
		&& avs_byteenable[0] && !a_is_out[0])
		|=> (st_r.port_a_pin_data[0] == $past(avs_writedata[0]) && port_a_pin_oe_n[0]))
		else $error("port a input mode write drove or missed");

	b_in_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_write && avs_waitrequest && avs_address == port_b_data_addr
		&& avs_byteenable[0] && !b_is_out[0])
		|=> (st_r.port_b_pin_data[0] == $past(avs_writedata[0]) && port_b_pin_oe_n[0]))
		else $error("port b input mode write drove or missed");

	a_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(avs_write && avs_waitrequest && avs_address == port_a_data_addr)
		|=> $stable(st_r.port_a_pin_data))
		else $error("port a data moved without a write");

	b_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(avs_write && avs_waitrequest && avs_address == port_b_data_addr)
		|=> $stable(st_r.port_b_pin_data))
		else $error("port b data moved without a write");

	// pin drive per mode: only the output code enables a driver
	a_drive_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_a_function_control[1:0] == func_port_out)
		|-> (!port_a_pin_oe_n[0] && port_a_pin_out[0] == st_r.port_a_pin_data[0]))
		else $error("output pin not driven from data");

	a_top_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_a_function_control[29:28] == func_port_out)
		|-> (!port_a_pin_oe_n[14] && port_a_pin_out[14] == st_r.port_a_pin_data[14]))
		else $error("port a top pin not driven from data");

	b_drive_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_b_function_control[1:0] == func_port_out)
		|-> (!port_b_pin_oe_n[0] && port_b_pin_out[0] == st_r.port_b_pin_data[0]))
		else $error("port b output pin not driven from data");

	b_top_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_b_function_control[17:16] == func_port_out)
		|-> (!port_b_pin_oe_n[8] && port_b_pin_out[8] == st_r.port_b_pin_data[8]))
		else $error("port b top pin not driven from data");

	b_no_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_b_function_control[1:0] != func_port_out)
		|-> port_b_pin_oe_n[0])
		else $error("non output pin driven");

	a_no_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_a_function_control[1:0] == func_port_in)
		|-> port_a_pin_oe_n[0])
		else $error("port a input pin driven");

	a_other_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_a_function_control[1:0] == func_other)
		|-> port_a_pin_oe_n[0])
		else $error("port a other function pin driven");

	a_rsvd_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(port_a_function_control[1:0] == func_reserved)
		|-> port_a_pin_oe_n[0])
		else $error("port a reserved code pin driven");

	// power-on clear holds through reset; synchronisers shift one step per clock
	a_por_clear_a: assert property (@(posedge clk_sys)
		!rst_n |-> st_r.port_a_pin_data == port_a_reset[port_a_width-1:0])
		else $error("port a data not cleared in reset");

	b_por_clear_a: assert property (@(posedge clk_sys)
		!rst_n |-> st_r.port_b_pin_data == port_b_reset[port_b_width-1:0])
		else $error("port b data not cleared in reset");

	a_sync_chain_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> st_r.a_sync2 == $past(st_r.a_sync1))
		else $error("port a synchroniser skipped a stage");

	b_sync_chain_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> st_r.b_sync2 == $past(st_r.b_sync1))
		else $error("port b synchroniser skipped a stage");

endmodule // gpio_port_a_b_data

/* File: test/pin_model.sv */
// package pins: the block's drive where enabled, else the outside level
`timescale 1ns/1ps
module pin_model
#(
	parameter int w = 15
)
(
	// block side
	input wire logic [w-1:0] drv,
	input wire logic [w-1:0] oe_n,
	// outside level and resolved pin
	input wire logic [w-1:0] ext,
	output logic [w-1:0] lvl
);
	// undriven bits follow the outside source
	assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule // pin_model

/* File: test/tb.sv */
// self-checking bench for the port a / port b data registers
`timescale 1ns/1ps
module tb;
	import gpio_ab_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata, q;
	logic wait_r;
	logic [29:0] sel_a = {15{2'h1}};
	logic [17:0] sel_b = {9{2'h1}};
	logic [14:0] ext_a = 15'h0, a_out, a_oe_n, a_in;
	logic [8:0] ext_b = 9'h0, b_out, b_oe_n, b_in;
	int failures = 0;
	int compares = 0;
	// clock
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end
	gpio_port_a_b_data uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdata), .avs_waitrequest(wait_r), .port_a_function_control(sel_a),
		.port_b_function_control(sel_b), .port_a_pin_in(a_in), .port_a_pin_out(a_out),
		.port_a_pin_oe_n(a_oe_n), .port_b_pin_in(b_in), .port_b_pin_out(b_out),
		.port_b_pin_oe_n(b_oe_n));
	pin_model #(.w(15)) pa (.drv(a_out), .oe_n(a_oe_n), .ext(ext_a), .lvl(a_in));
	pin_model #(.w(9)) pb (.drv(b_out), .oe_n(b_oe_n), .ext(ext_b), .lvl(b_in));
	task automatic summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon access; held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		logic ws;
		int n;
		n = 0;
		ws = 1'b1;
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		while (ws)
		begin
			@(posedge clk_sys);
			ws = wait_r;
			q = rdata;
			n++;
			if (ws && n > 20)
			begin
				failures++;
				summarize();
			end
		end
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic t_out;
		bus(1'b0, port_a_data_addr, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, port_b_data_addr, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, port_a_data_addr, 32'h00004321);
		bus(1'b1, port_b_data_addr, 32'h00000155);
		bus(1'b0, port_a_data_addr, 32'h0);
		chk(q, 32'h00004321);
		bus(1'b0, port_b_data_addr, 32'h0);
		chk(q, 32'h00000155);
		chk({8'h00, a_in, b_in}, 32'h00864355);
		$display("test output done");
	endtask
	task automatic t_modes;
		logic [1:0] c [3] = '{func_port_in, func_reserved, func_other};
		for (int i = 0; i < 3; i++)
		begin
			sel_a <= {15{c[i]}};
			sel_b <= {9{c[i]}};
			ext_a <= 15'h3CDE;
			ext_b <= 9'h0AA;
			repeat (4) @(posedge clk_sys);
			bus(1'b0, port_a_data_addr, 32'h0);
			chk(q, 32'h00003CDE);
			bus(1'b0, port_b_data_addr, 32'h0);
			chk(q, 32'h000000AA);
			bus(1'b1, port_a_data_addr, 32'h00001111);
			bus(1'b1, port_b_data_addr, 32'h000000F0);
			chk({23'h0, b_in}, 32'h000000AA);
			chk({8'h00, a_oe_n, b_oe_n}, 32'h00FFFFFF);
			chk({17'h0, a_in}, 32'h00003CDE);
			sel_a <= {15{func_port_out}};
			bus(1'b0, port_a_data_addr, 32'h0);
			chk(q, 32'h00001111);
		end
		$display("test modes done");
	endtask
	task automatic t_unmapped;
		bus(1'b1, 4'h8, 32'h0000FFFF);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, unmapped_read);
		bus(1'b0, port_a_data_addr, 32'h0);
		chk(q, 32'h00001111);
		$display("test unmapped done");
	endtask
	task automatic t_reset;
		sel_b <= {9{func_port_out}};
		bus(1'b1, port_a_data_addr, 32'h00000ABC);
		bus(1'b1, port_b_data_addr, 32'h000000CD);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		chk({8'h00, a_in, b_in}, 32'h0);
		bus(1'b0, port_a_data_addr, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, port_b_data_addr, 32'h0);
		chk(q, 32'h0);
		$display("test reset done");
	endtask
	// reset for 20 cycles, then the scenarios
	initial
	begin
		rst_n <= 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_out();
		t_modes();
		t_unmapped();
		t_reset();
		summarize();
	end
endmodule // tb
